// *** hdl/cfg_regs_params.svh ***
// constants for the bus status and class code register bank
// Notes on behaviour
// [R1] parity error seen in address or data phase sets status bit 15
// [R2] system error signalled to host sets status bit 14, only when enabled
// [R3] master abort on own master cycle sets status bit 13
// [R4] target abort received on own master cycle sets status bit 12
// [R5] target abort signalled as target sets status bit 11
// [R6] devsel timing field reads 01b, medium speed
// [R7] bit 8 set when perr seen, we are master, response enabled
// [R8] bit 7 reads zero, no fast back-to-back
// [R9] bit 6 reads zero, no user-definable features
// [R10] bit 5 reads zero, not high-speed capable
// [R11] bit 4 reads one, capability list present
// [R12] bits 3 to 0 read zero
// [R13] base class byte reads 0c, serial bus controller
// [R14] subclass byte reads zero
// [R15] programming interface byte reads 10
// [R16] low byte reports silicon revision, read only
// [R17] system error output driven only while its enable is set
// [R18] parity error response driven only while its enable is set
// [R19] flags stay set until a one is written to them
// [R20] writes to read-only fields are ignored
`ifndef CFG_REGS_PARAMS_SVH
`define CFG_REGS_PARAMS_SVH
`define OFS_STATUS 8'h06
`define OFS_CLASS 8'h08
`define STATUS_RESET 16'h0210
`define BIT_PAR 15
`define BIT_SERR 14
`define BIT_MABT 13
`define BIT_TABT_RX 12
`define BIT_TABT_TX 11
`define BIT_DPAR 8
`define DEVSEL_MEDIUM 2'h1
`define CLASS_BASE 8'h0c
`define CLASS_SUB 8'h00
`define CLASS_PROGRAMMING_INTERFACE_BYTE 8'h10
`define SILICON_REV_DEFAULT 8'h5a
`endif

// *** hdl/cfg_pkg.sv ***
// types shared by the status register bank
package cfg_pkg;
    typedef logic [15:0] half_t;
    typedef logic [31:0] word_t;
endpackage

// *** hdl/err_event_if.sv ***
// carrier for sticky error events between top and flag store
interface err_event_if;
    logic [15:0] set_mask;
    logic [15:0] clr_mask;
    logic [15:0] flags;
    modport src (output set_mask, output clr_mask, input flags);
    modport store (input set_mask, input clr_mask, output flags);
endinterface

// *** hdl/sticky_flags.sv ***
// sticky status flags with write-one-to-clear
`include "cfg_regs_params.svh"
module sticky_flags
    import cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // events
    err_event_if.store ev
);
    localparam half_t flag_bits = 16'hf900;
    half_t flags_q;
    half_t flags_d;

    // set wins over clear so an event in the clearing cycle survives
    assign flags_d = ((flags_q & ~ev.clr_mask) | ev.set_mask) & flag_bits; // R19
    assign ev.flags = flags_q;

    // flag register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_q <= 16'h0000;
        end else begin
            flags_q <= flags_d;
        end
    end

    a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (rst)
        ev.set_mask[`BIT_PAR] |=> flags_q[`BIT_PAR]) // R19
        else $error("flag lost when set and clear coincide");
    a_flag_holds: assert property (@(posedge clk_sys) disable iff (rst)
        flags_q[`BIT_MABT] && !ev.clr_mask[`BIT_MABT] |=> flags_q[`BIT_MABT]) // R19
        else $error("sticky flag dropped without clear");
endmodule // sticky_flags

// *** hdl/cfg_status_class.sv ***
// configuration status and class code registers
`include "cfg_regs_params.svh"
module cfg_status_class
    import cfg_pkg::*;
#(
    parameter logic [7:0] SILICON_REV = `SILICON_REV_DEFAULT // arbitrary value
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // enables from command register
    input wire logic system_error_enable,
    input wire logic parity_response_enable,
    // bus events, same clock
    input wire logic addr_parity_err,
    input wire logic data_parity_err,
    input wire logic perr_seen,
    input wire logic master_phase,
    input wire logic master_abort_rx,
    input wire logic target_abort_rx,
    input wire logic target_abort_tx,
    // error outputs
    output logic serr_req,
    output logic perr_req,
    // status view
    output logic [15:0] bus_status
);
    err_event_if ev ();
    half_t set_mask;
    half_t clr_mask;
    half_t status_word;
    word_t class_word;
    word_t rdata_d;
    logic sel_status;
    logic hit_status;
    logic hit_class;
    logic serr_d;
    logic perr_d;
    logic serr_q;
    logic perr_q;

    // system error only with enable, after address parity error
    assign serr_d = addr_parity_err & system_error_enable; // R17
    // parity response only with enable
    assign perr_d = data_parity_err & parity_response_enable; // R18

    // event set mask
    always_comb begin
        set_mask = 16'h0000;
        set_mask[`BIT_PAR] = addr_parity_err | data_parity_err; // R1
        set_mask[`BIT_SERR] = serr_d; // R2
        set_mask[`BIT_MABT] = master_abort_rx; // R3
        set_mask[`BIT_TABT_RX] = target_abort_rx; // R4
        set_mask[`BIT_TABT_TX] = target_abort_tx; // R5
        set_mask[`BIT_DPAR] = perr_seen & master_phase & parity_response_enable; // R7
    end

    // dword match; byte offsets inside the dword do not matter
    function automatic logic dword_is(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    // status halfword sits at byte lanes 3:2 of the dword at 04
    assign sel_status = dword_is(cfg_addr, `OFS_STATUS);
    assign hit_status = cfg_wr && sel_status;
    assign hit_class = dword_is(cfg_addr, `OFS_CLASS);
    assign clr_mask = hit_status ? {cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
                                    cfg_be[2] ? cfg_wdata[23:16] : 8'h00} : 16'h0000; // R19

    assign ev.set_mask = set_mask;
    assign ev.clr_mask = clr_mask;

    sticky_flags u_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .ev(ev)
    );

    // read-only fields are constants, so writes cannot reach them
    assign status_word = ev.flags | {5'h00, `DEVSEL_MEDIUM, 1'b0, // R6 R20
                                     1'b0, 1'b0, 1'b0, // R8 R9 R10
                                     1'b1, 4'h0}; // R11 R12
    assign class_word = {`CLASS_BASE, `CLASS_SUB, `CLASS_PROGRAMMING_INTERFACE_BYTE, SILICON_REV}; // R13 R14 R15 R16

    // read mux; unmapped dwords return zero
    assign rdata_d = sel_status ? {status_word, 16'h0000} :
                     hit_class ? class_word : 32'h0000_0000;

    // registered outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 32'h0000_0000;
            serr_q <= 1'b0;
            perr_q <= 1'b0;
        end else begin
            cfg_rdata <= cfg_rd ? rdata_d : 32'h0000_0000;
            serr_q <= serr_d;
            perr_q <= perr_d;
        end
    end

    assign serr_req = serr_q;
    assign perr_req = perr_q;
    assign bus_status = status_word;

    a_serr_needs_en: assert property (@(posedge clk_sys) disable iff (rst)
        serr_req |-> $past(system_error_enable)) // R17
        else $error("system error driven while disabled");
    a_perr_needs_en: assert property (@(posedge clk_sys) disable iff (rst)
        perr_req |-> $past(parity_response_enable)) // R18
        else $error("parity response driven while disabled");
    a_par_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        (addr_parity_err || data_parity_err) |=> bus_status[15]) // R1
        else $error("detected parity flag not set");
    a_serr_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        serr_d |=> bus_status[14] && serr_req) // R2
        else $error("system error flag not set");
    a_mabt_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        master_abort_rx |=> bus_status[13]) // R3
        else $error("master abort flag not set");
    a_tabt_rx_set: assert property (@(posedge clk_sys) disable iff (rst)
        target_abort_rx |=> bus_status[12]) // R4
        else $error("received target abort flag not set");
    a_tabt_tx_set: assert property (@(posedge clk_sys) disable iff (rst)
        target_abort_tx |=> bus_status[11]) // R5
        else $error("signaled target abort flag not set");
    a_dpar_cond: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(bus_status[8]) |-> $past(perr_seen && master_phase && parity_response_enable)) // R7
        else $error("data parity flag set without cause");
    a_const_fields: assert property (@(posedge clk_sys) disable iff (rst)
        bus_status[10:0] == {2'h1, bus_status[8], 8'h10}) // R6 R8 R9 R10 R11 R12
        else $error("hardwired status bits wrong");
    a_class_read: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_rd && hit_class |=> cfg_rdata == {24'h0c0010, SILICON_REV}) // R13 R14 R15 R16 R20
        else $error("class code read wrong");
    a_clear_works: assert property (@(posedge clk_sys) disable iff (rst)
        hit_status && cfg_be[3] && cfg_wdata[29] && !master_abort_rx |=> !bus_status[13]) // R19
        else $error("write one did not clear flag");

    c_detected_parity_flag: cover property (@(posedge clk_sys) addr_parity_err && system_error_enable);
    c_clear_flag: cover property (@(posedge clk_sys) $fell(bus_status[13]));
    c_dpar: cover property (@(posedge clk_sys) $rose(bus_status[8]));
endmodule // cfg_status_class

// *** tb/cfg_host.sv ***
// host bridge model issuing configuration cycles
module cfg_host (
    // clock
    input wire logic clk_sys,
    // configuration access
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // launched after a falling edge, held through the taking edge
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        @(negedge clk_sys);
        cfg_wr = w;
        cfg_rd = ~w;
        cfg_addr = a;
        cfg_be = b;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        // released lines flip so a stale value never looks valid
        cfg_addr = ~a;
        cfg_be = ~b;
        cfg_wdata = ~d;
    endtask
endmodule // cfg_host

// *** tb/pci_cfg_status_class_regs_tb_top.sv ***
// self-checking bench for the status and class code registers
module pci_cfg_status_class_regs_tb_top import cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'ha3; // arbitrary revision
    // event, enables, serr, perr, flags set
    localparam logic [26:0] TBL [10] = '{
        {7'h40, 2'h1, 2'h0, 16'h8000}, {7'h40, 2'h3, 2'h2, 16'hc000},
        {7'h20, 2'h3, 2'h1, 16'h8000}, {7'h20, 2'h2, 2'h0, 16'h8000},
        {7'h18, 2'h3, 2'h0, 16'h0100}, {7'h18, 2'h0, 2'h0, 16'h0000},
        {7'h10, 2'h3, 2'h0, 16'h0000}, {7'h04, 2'h0, 2'h0, 16'h2000},
        {7'h02, 2'h0, 2'h0, 16'h1000}, {7'h01, 2'h0, 2'h0, 16'h0800}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic taken = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [1:0] en = 2'h0;
    logic cfg_wr, cfg_rd, serr_req, perr_req;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    word_t cfg_wdata, cfg_rdata, r;
    half_t bus_status;
    word_t exp_q[$];
    int mismatches = 0;
    int tests_run = 0;
    integer seed = 32'h6942a120;
    always #5 clk_sys = ~clk_sys;
    cfg_host u_host (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    cfg_status_class #(.SILICON_REV(REV)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .system_error_enable(en[1]),
        .parity_response_enable(en[0]), .addr_parity_err(ev[6]),
        .data_parity_err(ev[5]), .perr_seen(ev[4]), .master_phase(ev[3]),
        .master_abort_rx(ev[2]), .target_abort_rx(ev[1]), .target_abort_tx(ev[0]),
        .serr_req(serr_req), .perr_req(perr_req), .bus_status(bus_status));
    task automatic check(input string nm, input word_t seen, input word_t exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input word_t e);
        exp_q.push_back(e);
        u_host.access(1'b0, a, 4'hf, 32'h0);
    endtask
    // one event pulse, outputs looked at one cycle later
    task automatic pulse(input logic [26:0] t);
        @(negedge clk_sys);
        ev = t[26:20];
        en = t[19:18];
        @(negedge clk_sys);
        ev = 7'h00;
        check("serr_req", {31'h0, serr_req}, {31'h0, t[17]});
        check("perr_req", {31'h0, perr_req}, {31'h0, t[16]});
        check("bus_status", {16'h0, bus_status}, {16'h0, 16'h0210 | t[15:0]});
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // read data stands one cycle, so it is compared in that cycle
    always @(posedge clk_sys) taken <= cfg_rd;
    always @(negedge clk_sys) begin
        if (taken) check("cfg_rdata", cfg_rdata, exp_q.pop_front());
    end
    // watchdog far beyond the fewer than two hundred cycles the run needs
    initial begin
        #50000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'h08, {8'h0c, 8'h00, 8'h10, REV});
        rd(8'h04, 32'h0210_0000);
        rd(8'h10, 32'h0);
        $display("test identity done");
        repeat (4) begin
            r = $random(seed);
            u_host.access(1'b1, 8'h08, 4'hf, r);
            u_host.access(1'b1, 8'h04, 4'hf, r & 32'h06ff_ffff);
            rd(8'h08, {8'h0c, 8'h00, 8'h10, REV});
            rd(8'h04, 32'h0210_0000);
        end
        $display("test read-only writes done");
        foreach (TBL[i]) begin
            pulse(TBL[i]);
            u_host.access(1'b1, 8'h04, 4'hc, 32'h0);
            rd(8'h04, {16'h0210 | TBL[i][15:0], 16'h0});
            u_host.access(1'b1, 8'h04, 4'hc, {TBL[i][15:0], 16'h0});
            rd(8'h04, 32'h0210_0000);
        end
        $display("test event flags done");
        @(negedge clk_sys);
        stop_test();
    end
endmodule // pci_cfg_status_class_regs_tb_top
